/* design/hs_cfg.svh */
`ifndef HS_CFG_SVH
`define HS_CFG_SVH

// register byte offsets
`define HS_REG_CTRL 8'h00
`define HS_REG_INC 8'h04
`define HS_REG_LINE 8'h08
`define HS_REG_COEF 8'h0C
`define HS_REG_STAT 8'h10

// control register bits
`define HS_CTRL_START 0
`define HS_CTRL_BYPASS 1
`define HS_CTRL_PCI 2
`define HS_CTRL_MIRS 3
`define HS_CTRL_MIRE 4

// coefficient write fields
`define HS_COEF_VAL_LSB 0
`define HS_COEF_IDX_LSB 8
`define HS_COEF_TAP_LSB 16

// increment reset value: integer 1, fraction 0
`define HS_INC_INT_RST 4'h1
`define HS_INC_FRAC_RST 16'h0000

`define HS_TAPS 5
`define HS_EDGE 2
`define HS_FRAC_W 16
`define HS_IDX_W 5
`define HS_IDX_LSB 11
`define HS_PIPE_CLKS 5
`define HS_COEF_SHIFT 6
`define HS_FILL_FULL 3'h5
`define HS_FILL_MIR 3'h3

// filter rate against block transfer rate, pixels per word written
`define HS_FILT_MPIX 100
`define HS_XFER_MPIX 400
`define HS_PIX_PER_WORD (`HS_XFER_MPIX / `HS_FILT_MPIX)

`endif

/* design/hs_pkg.sv */
package hs_pkg;

  typedef enum logic [1:0] {st_idle, st_fill, st_run, st_byp} hs_state_e;

  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [31:0] data;
  } hs_blk_wr_s;

  typedef struct packed {
    logic valid;
    logic bypass;
    logic to_pci;
    logic [31:0] data;
  } hs_out_s;

endpackage : hs_pkg

/* design/hs_scaler.sv */
// Behaviour
// - bypass path moves blocks around filter unchanged
// - output goes to SDRAM or PCI path
// - position selects buffer word and byte
// - pending steps advance position, count down
// - step adds fraction, loads pending steps
// - unity scale: increment one, fraction zero
// - span a..b reads a-2 (a with start mirror) through b+2
// - output is weighted sum of five pixels
// - increment is reciprocal of scale factor
// - five coefficient RAMs, index from fraction top
// - shift pixel only when position changes
// - stall filter until needed pixels shifted
// - 16-bit fraction, top five bits index
// - pipeline five clocks, rightmost tap first
// - each stage carries pixel and its index
// - low eleven fraction bits give precision carry
// - input selector substitutes mirrored edge pixels
// - mirrors use pixels adjacent to edge pixel
// - start: first two; end: pixel counter
// - next block prefetched while current filtered
// - filter quarter rate of block transfer
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "hs_cfg.svh"

module hs_scaler #(
  parameter int LEN_W = 8
)(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // block buffer fill side
  input wire hs_pkg::hs_blk_wr_s blk_wr,
  input wire logic blk_done,
  input wire logic blk_half,
  output logic [1:0] buf_full,
  // pixel output
  output hs_pkg::hs_out_s pix_out
);
  import hs_pkg::*;

  logic bypass_r, to_pci_r, mir_s_r, mir_e_r, start_r, done_r;
  logic [3:0] inc_int_r;
  logic [15:0] inc_frac_r;
  logic [6:0] spos_r;
  logic [LEN_W-1:0] len_r;
  logic signed [7:0] coef_mem [0:4][0:31];
  logic [31:0] buf_mem [0:31];
  logic [1:0] buf_full_r;
  hs_state_e st_r;
  logic [6:0] pos_r, pos_nxt;
  logic [15:0] frac_r;
  logic [4:0] pend_r, step_cnt;
  logic [2:0] fill_r;
  logic [LEN_W-1:0] ocnt_r, last_idx;
  logic [7:0] win_r [0:4];
  logic [7:0] mir_pix [0:4];
  logic [31:0] cur_word, rd_val, hrdata_r;
  logic [7:0] cur_pix;
  logic [16:0] frac_sum;
  logic half_ok, want_shift, do_shift, issue, do_byp, adv, pipe_busy;
  logic ahb_go, wr_pend_r, hreadyout_r;
  logic [7:0] wr_addr_r;
  logic [39:0] in_pix;
  logic signed [16:0] prod_last;
  logic signed [18:0] total;
  logic signed [18:0] scaled;
  logic [7:0] clamp_pix;
  hs_out_s pix_out_r;

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign buf_full = buf_full_r;
  assign pix_out = pix_out_r;

  // bus slave: zero wait states, reads sampled in the address phase
  assign ahb_go = hsel && hready && htrans[1];

  always_comb
  begin
    case (haddr[7:0])
      `HS_REG_CTRL: rd_val = {27'h0, mir_e_r, mir_s_r, to_pci_r, bypass_r, 1'b0};
      `HS_REG_INC: rd_val = {12'h0, inc_int_r, inc_frac_r};
      `HS_REG_LINE: rd_val = {8'h0, 8'(len_r), 9'h0, spos_r};
      `HS_REG_STAT: rd_val = {frac_r, 1'b0, pos_r, 6'h0, done_r, st_r != st_idle || pipe_busy};
      default: rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0;
      hreadyout_r <= 1'b1;
    end
    else if (ce)
    begin
      wr_pend_r <= ahb_go && hwrite;
      wr_addr_r <= haddr[7:0];
      hrdata_r <= (ahb_go && !hwrite) ? rd_val : 32'h0;
    end
  end

  // control registers written in the data phase
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bypass_r <= 1'b0;
      to_pci_r <= 1'b0;
      mir_s_r <= 1'b0;
      mir_e_r <= 1'b0;
      start_r <= 1'b0;
      inc_int_r <= `HS_INC_INT_RST;
      inc_frac_r <= `HS_INC_FRAC_RST;
      spos_r <= 7'h00;
      len_r <= '0;
    end
    else if (ce)
    begin
      start_r <= 1'b0;
      if (wr_pend_r && wr_addr_r == `HS_REG_CTRL)
      begin
        start_r <= hwdata[`HS_CTRL_START];
        bypass_r <= hwdata[`HS_CTRL_BYPASS];
        to_pci_r <= hwdata[`HS_CTRL_PCI];
        mir_s_r <= hwdata[`HS_CTRL_MIRS];
        mir_e_r <= hwdata[`HS_CTRL_MIRE];
      end
      // software loads 1/scale here, e.g. 0x08000 for 2x up
      if (wr_pend_r && wr_addr_r == `HS_REG_INC)
      begin
        inc_int_r <= hwdata[19:16];
        inc_frac_r <= hwdata[15:0];
      end
      if (wr_pend_r && wr_addr_r == `HS_REG_LINE)
      begin
        spos_r <= hwdata[6:0];
        len_r <= hwdata[16 +: LEN_W];
      end
    end
  end

  // tap t weighs pixel x+t-2; no reset on the tables
  always_ff @(posedge mclk)
  begin
    if (ce && wr_pend_r && wr_addr_r == `HS_REG_COEF && hwdata[18:16] < 3'(`HS_TAPS))
      coef_mem[hwdata[18:16]][hwdata[12:8]] <= hwdata[7:0];
  end

  // two-block buffer: the fill side writes one half while the other is filtered
  always_ff @(posedge mclk)
  begin
    if (blk_wr.en && ce)
      buf_mem[blk_wr.addr] <= blk_wr.data;
  end

  assign cur_word = buf_mem[pos_r[6:2]];
  assign cur_pix = cur_word[{pos_r[1:0], 3'b000} +: 8];
  assign half_ok = buf_full_r[pos_r[6]];

  assign want_shift = (st_r == st_fill && fill_r != 3'h0) || (st_r == st_run && pend_r != 5'h0);
  assign do_shift = want_shift && half_ok;
  assign issue = st_r == st_run && pend_r == 5'h0;
  assign do_byp = st_r == st_byp && half_ok;
  assign adv = do_shift || do_byp;
  assign pos_nxt = do_byp ? pos_r + 7'd4 : pos_r + 7'd1;
  assign frac_sum = {1'b0, frac_r} + {1'b0, inc_frac_r};
  assign step_cnt = {1'b0, inc_int_r} + {4'h0, frac_sum[16]};
  assign last_idx = len_r - 1'b1;

  // half released once the position leaves it; a new fill wins over release
  always_ff @(posedge mclk)
  begin
    if (rst)
      buf_full_r <= 2'b00;
    else if (ce)
    begin
      for (int h = 0; h < 2; h++)
      begin
        if (blk_done && blk_half == h[0])
          buf_full_r[h] <= 1'b1;
        else if (adv && pos_nxt[6] != pos_r[6] && pos_r[6] == h[0])
          buf_full_r[h] <= 1'b0;
      end
    end
  end

  // position engine
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_r <= st_idle;
      pos_r <= 7'h00;
      frac_r <= 16'h0000;
      pend_r <= 5'h00;
      fill_r <= 3'h0;
      ocnt_r <= '0;
      done_r <= 1'b0;
    end
    else if (ce)
    begin
      case (st_r)
        st_idle:
        begin
          if (start_r && !pipe_busy)
          begin
            frac_r <= 16'h0000;
            pend_r <= 5'h00;
            ocnt_r <= '0;
            done_r <= 1'b0;
            if (bypass_r)
            begin
              pos_r <= spos_r;
              st_r <= st_byp;
            end
            else if (mir_s_r)
            begin
              pos_r <= spos_r;
              fill_r <= `HS_FILL_MIR;
              st_r <= st_fill;
            end
            else
            begin
              pos_r <= spos_r - 7'(`HS_EDGE);
              fill_r <= `HS_FILL_FULL;
              st_r <= st_fill;
            end
          end
        end
        st_fill:
        begin
          if (do_shift)
          begin
            pos_r <= pos_nxt;
            fill_r <= fill_r - 3'h1;
            if (fill_r == 3'h1)
              st_r <= st_run;
          end
        end
        st_run:
        begin
          if (pend_r != 5'h00)
          begin
            if (do_shift)
            begin
              pos_r <= pos_nxt;
              pend_r <= pend_r - 5'h01;
            end
          end
          else
          begin
            frac_r <= frac_sum[15:0];
            pend_r <= step_cnt;
            ocnt_r <= ocnt_r + 1'b1;
            // pixels past b are still fetched to fill the window
            if (ocnt_r == last_idx)
            begin
              st_r <= st_idle;
              done_r <= 1'b1;
            end
          end
        end
        st_byp:
        begin
          if (do_byp)
          begin
            pos_r <= pos_nxt;
            ocnt_r <= ocnt_r + 1'b1;
            if (ocnt_r == last_idx)
            begin
              st_r <= st_idle;
              done_r <= 1'b1;
            end
          end
        end
        default: st_r <= st_idle;
      endcase
    end
  end

  // window: index 0 newest (rightmost), 4 oldest
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int k = 0; k < `HS_TAPS; k++)
        win_r[k] <= 8'h00;
    end
    else if (ce && do_shift)
    begin
      win_r[0] <= cur_pix;
      for (int k = 1; k < `HS_TAPS; k++)
        win_r[k] <= win_r[k-1];
    end
  end

  // mirror selector; missing taps reflect about the edge pixel
  always_comb
  begin
    for (int k = 0; k < `HS_TAPS; k++)
      mir_pix[k] = win_r[k];
    if (mir_s_r && ocnt_r == '0)
    begin
      mir_pix[4] = win_r[0];
      mir_pix[3] = win_r[1];
    end
    if (mir_s_r && ocnt_r == LEN_W'(1))
      mir_pix[4] = win_r[2];
    if (mir_e_r && ocnt_r == last_idx)
    begin
      mir_pix[1] = win_r[3];
      mir_pix[0] = win_r[4];
    end
    if (mir_e_r && ocnt_r == last_idx - 1'b1)
      mir_pix[0] = win_r[2];
  end

  assign in_pix = {mir_pix[4], mir_pix[3], mir_pix[2], mir_pix[1], mir_pix[0]};

  // stage k forms the tap for pixel x+2-k; last tap is in the output stage
  for (genvar k = 0; k < `HS_TAPS - 1; k++)
  begin : g_st
    logic [39:0] sp, p_r;
    logic [4:0] si, i_r;
    logic signed [18:0] ss, s_r;
    logic sv, v_r;
    logic signed [16:0] prod;
    if (k == 0)
    begin : g_in
      assign sp = in_pix;
      assign si = frac_r[15:11];
      assign ss = 19'sh0;
      assign sv = issue;
    end
    else
    begin : g_prev
      assign sp = g_st[k-1].p_r;
      assign si = g_st[k-1].i_r;
      assign ss = g_st[k-1].s_r;
      assign sv = g_st[k-1].v_r;
    end
    assign prod = $signed({1'b0, sp[8*k +: 8]}) * coef_mem[`HS_TAPS-1-k][si];
    always_ff @(posedge mclk)
    begin
      if (rst)
      begin
        v_r <= 1'b0;
        p_r <= 40'h0;
        i_r <= 5'h00;
        s_r <= 19'sh0;
      end
      else if (ce)
      begin
        v_r <= sv;
        p_r <= sp;
        i_r <= si;
        s_r <= ss + 19'(prod);
      end
    end
  end

  assign pipe_busy = g_st[0].v_r || g_st[1].v_r || g_st[2].v_r || g_st[3].v_r || pix_out_r.valid;
  assign prod_last = $signed({1'b0, g_st[3].p_r[39:32]}) * coef_mem[0][g_st[3].i_r];
  assign total = g_st[3].s_r + 19'(prod_last);
  assign scaled = total >>> `HS_COEF_SHIFT;

  // saturate rather than wrap: overshoot from negative lobes is normal
  always_comb
  begin
    if (scaled < 0)
      clamp_pix = 8'h00;
    else if (scaled > 19'sd255)
      clamp_pix = 8'hFF;
    else
      clamp_pix = scaled[7:0];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      pix_out_r <= '0;
    else if (ce)
    begin
      pix_out_r.valid <= g_st[3].v_r || do_byp;
      pix_out_r.bypass <= do_byp;
      pix_out_r.to_pci <= to_pci_r;
      pix_out_r.data <= do_byp ? cur_word : {24'h0, clamp_pix};
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_issue;
    issue && ce;
  endsequence

  sequence s_flow4;
    ce[*4];
  endsequence

  chk_pend_count: assert property (st_r == st_run && pend_r != 5'h0 && half_ok && ce
    |=> pend_r == $past(pend_r) - 5'h1 && pos_r == $past(pos_r) + 7'd1)
    else $error("pending step did not advance position");

  chk_step_load: assert property (s_issue
    |=> pend_r == $past(step_cnt) && frac_r == 16'($past(frac_sum)))
    else $error("step did not load fraction and pending count");

  chk_unity_frac: assert property (s_issue and (inc_int_r == 4'h1 && inc_frac_r == 16'h0 && frac_r == 16'h0)
    |=> frac_r == 16'h0 && pend_r == 5'h1)
    else $error("unity increment moved the fraction");

  chk_pipe_delay: assert property (s_issue ##1 s_flow4 |=> pix_out_r.valid && !pix_out_r.bypass)
    else $error("filter result not out five clocks after issue");

  chk_shift_gate: assert property (ce && !do_shift |=> $stable(win_r[0]))
    else $error("window shifted without a position change");

  chk_line_start: assert property (st_r == st_idle && start_r && !pipe_busy && ce && !bypass_r && !mir_s_r
    |=> frac_r == 16'h0 && pend_r == 5'h0 && pos_r == $past(spos_r) - 7'd2)
    else $error("line start did not load a-2 and clear counters");

  chk_coef_index: assert property (s_issue |=> g_st[0].i_r == 5'($past(frac_r) >> 11))
    else $error("coefficient index not the fraction top bits");

  chk_bypass_data: assert property (do_byp && ce
    |=> pix_out_r.valid && pix_out_r.bypass && pix_out_r.data == $past(cur_word))
    else $error("bypass word altered");

  chk_out_route: assert property (pix_out_r.valid && $stable(to_pci_r) |-> pix_out_r.to_pci == to_pci_r)
    else $error("output routed to wrong path");

endmodule : hs_scaler
`default_nettype wire

/* sim/hs_fill_model.sv */
`timescale 1ns/1ps
`default_nettype none

module hs_fill_model (
  // clock, reset
  input wire logic mclk,
  input wire logic rst,
  // bench control: idle gap before each fill
  input wire logic slow,
  // buffer fill side
  input wire logic [1:0] buf_full,
  output hs_pkg::hs_blk_wr_s blk_wr,
  output logic blk_done,
  output logic blk_half
);
  import hs_pkg::*;
  logic busy_r;
  logic [4:0] cnt_r;
  logic [3:0] gap_r;
  logic [6:0] p;

  function automatic logic [7:0] pv(input logic [6:0] q);
    return {q, 1'b1};
  endfunction : pv

  assign p = {blk_half, cnt_r[3:0], 2'b00};

  always_ff @(posedge mclk)
  begin
    blk_done <= 1'b0;
    blk_wr.en <= 1'b0;
    // idle bus never repeats the last word
    blk_wr.addr <= ~blk_wr.addr;
    blk_wr.data <= ~blk_wr.data;
    if (rst)
    begin
      busy_r <= 1'b0;
      cnt_r <= 5'h00;
      gap_r <= 4'h0;
      blk_half <= 1'b0;
      blk_wr.data <= 32'h0;
    end
    else if (busy_r && !cnt_r[4])
    begin
      blk_wr.en <= 1'b1;
      blk_wr.addr <= {blk_half, cnt_r[3:0]};
      blk_wr.data <= {pv(p + 7'h3), pv(p + 7'h2), pv(p + 7'h1), pv(p)};
      cnt_r <= cnt_r + 5'h01;
    end
    else if (busy_r)
    begin
      blk_done <= 1'b1;
      busy_r <= 1'b0;
      cnt_r <= 5'h00;
    end
    else if (blk_done)
      blk_half <= ~blk_half;
    else if (buf_full != 2'b11)
    begin
      // refill whichever half the engine has released, ahead of it
      if (slow && gap_r != 4'hF)
        gap_r <= gap_r + 4'h1;
      else
      begin
        busy_r <= 1'b1;
        blk_half <= buf_full[0];
        gap_r <= 4'h0;
      end
    end
  end
endmodule : hs_fill_model

`default_nettype wire

/* sim/horizontal_scaler_5tap_filter_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module horizontal_scaler_5tap_filter_tb;
  import hs_pkg::*;
  logic mclk, rst, ce, hsel, hwrite, slow, gate, hreadyout, hresp, blk_done, blk_half;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, buf_full;
  logic [2:0] hsize;
  hs_blk_wr_s blk_wr;
  hs_out_s pix_out;
  hs_out_s got_q[$];
  int failures = 0;
  int cmp_count = 0;
  int cf[5][32];
  logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
  logic [31:0] rv[6] = '{32'h0, 32'h00010000, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] incs[5] = '{32'h00010000, 32'h00008000, 32'h00020000, 32'h00018000, 32'h00005555};

  hs_scaler #(.LEN_W(8)) i_dut (
    .mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .blk_wr(blk_wr), .blk_done(blk_done),
    .blk_half(blk_half), .buf_full(buf_full), .pix_out(pix_out)
  );

  hs_fill_model i_fill (
    .mclk(mclk), .rst(rst), .slow(slow), .buf_full(buf_full),
    .blk_wr(blk_wr), .blk_done(blk_done), .blk_half(blk_half)
  );

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk)
    if (pix_out.valid === 1'b1 && ce === 1'b1)
      got_q.push_back(pix_out);

  task automatic print_verdict;
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [34:0] got, input logic [34:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr_coef(input int t, input int i, input logic [7:0] v);
    ahb(1'b1, 8'h0C, {13'h0, 3'(t), 3'h0, 5'(i), v});
    if (t < 5)
      cf[t][i] = $signed(v);
  endtask : wr_coef

  function automatic int pv(input int p);
    return (p & 127) * 2 + 1;
  endfunction : pv

  function automatic int fir(input int x, input int k, input int n, input int idx, input logic ms, input logic me);
    int s, j;
    s = 0;
    for (int t = 0; t < 5; t++)
    begin
      j = k + t - 2;
      if (ms && j < 0)
        j = -j;
      if (me && j > n - 1)
        j = 2 * n - 2 - j;
      s += cf[t][idx] * pv(x - k + j);
    end
    s = s >>> 6;
    return (s < 0) ? 0 : (s > 255) ? 255 : s;
  endfunction : fir

  task automatic run_line(input logic [31:0] inc, input int a, input int n, input logic [4:0] ctl);
    logic [31:0] acc;
    hs_out_s e;
    int x, w;
    got_q = {};
    ahb(1'b1, 8'h04, inc);
    ahb(1'b1, 8'h08, {8'h00, 8'(n), 9'h0, 7'(a)});
    ahb(1'b1, 8'h00, {27'h0, ctl[4:1], 1'b1});
    w = 0;
    while (got_q.size() < n && w < 3000)
    begin
      @(posedge mclk);
      w++;
      // frozen cycles must leave every result unchanged
      ce <= !(gate && w[1:0] == 2'h3);
    end
    @(posedge mclk);
    ce <= 1'b1;
    do
    begin
      ahb(1'b0, 8'h10, 32'h0);
      w++;
    end
    while (rd[0] !== 1'b0 && w < 3300);
    check(35'(rd[1:0]), 35'h2);
    acc = n * inc;
    if (!ctl[1])
      check(35'(rd[31:16]), 35'(acc[15:0]));
    acc = (n - 1) * inc;
    check(35'(rd[14:8]), 35'(7'(ctl[1] ? a + 4 * n : a + acc[31:16] + 3)));
    check(35'(got_q.size()), 35'(n));
    for (int k = 0; k < n && k < got_q.size(); k++)
    begin
      acc = k * inc;
      x = a + acc[31:16];
      w = 4 * (a / 4 + k);
      e = '0;
      e.valid = 1'b1;
      e.bypass = ctl[1];
      e.to_pci = ctl[2];
      if (ctl[1])
        e.data = {8'(pv(w + 3)), 8'(pv(w + 2)), 8'(pv(w + 1)), 8'(pv(w))};
      else
        e.data = 32'(fir(x, k, n, acc[15:11], ctl[3], ctl[4]));
      check(got_q[k], e);
    end
  endtask : run_line

  initial
  begin
    repeat (60000) @(posedge mclk);
    failures++;
    print_verdict();
  end

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    slow = 1'b0;
    gate = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    hsel <= 1'b1;
    @(posedge mclk);
    check(35'(hresp), 35'h0);
    check(35'(buf_full), 35'h0);
    for (int i = 0; i < 6; i++)
    begin
      ahb(1'b0, ra[i], 32'h0);
      check(35'(rd), 35'(rv[i]));
    end
    ahb(1'b1, 8'h20, 32'hFFFFFFFF);
    ahb(1'b0, 8'h20, 32'h0);
    check(35'(rd), 35'h0);
    ahb(1'b1, 8'h00, 32'h0000001E);
    ahb(1'b0, 8'h00, 32'h0);
    check(35'(rd), 35'h1E);
    ahb(1'b1, 8'h00, 32'h0);
    // taps other than the centre stay zero so each scale isolates the index
    for (int t = 0; t < 5; t++)
      for (int i = 0; i < 32; i++)
        wr_coef(t, i, (t == 2) ? 8'(64 - i) : 8'h00);
    wr_coef(5, 0, 8'h7F);
    check(35'(buf_full), 35'h3);
    for (int i = 0; i < 5; i++)
      run_line(incs[i], 20, 8, {2'b00, i[0], 2'b00});
    slow <= 1'b1;
    run_line(32'h00030000, 100, 40, 5'h00);
    slow <= 1'b0;
    run_line(32'h00010000, 8, 3, 5'h06);
    gate <= 1'b1;
    for (int t = 0; t < 5; t++)
    begin
      for (int j = 0; j < 5; j++)
        wr_coef(j, 0, (j == t) ? 8'h40 : 8'h00);
      for (int m = 0; m < 4; m++)
        run_line(32'h00010000, 40, 5, {m[1:0], t[0], 2'b00});
    end
    print_verdict();
  end
endmodule : horizontal_scaler_5tap_filter_tb

`default_nettype wire
